/* File: core/lhp_pkg.sv */
// Constants and types shared by the display host bus port
package lhp_pkg;

    // ========================================================
    // APB register byte offsets
    localparam logic [7:0] LHP_OFS_CTRL   = 8'h00;
    localparam logic [7:0] LHP_OFS_STATUS = 8'h04;
    localparam logic [7:0] LHP_OFS_RXDATA = 8'h08;
    localparam logic [7:0] LHP_OFS_RDDATA = 8'h0C;
    localparam logic [7:0] LHP_OFS_HSTAT  = 8'h10;
    localparam logic [7:0] LHP_OFS_EVENTS = 8'h14;

    // ========================================================
    // Field positions
    localparam int LHP_CTRL_DISP_ON   = 0;
    localparam int LHP_CTRL_STATIC_ON = 1;
    localparam int LHP_EV_RX_VALID    = 0;
    localparam int LHP_EV_RX_OVERRUN  = 1;
    localparam int LHP_EV_RD_TAKEN    = 2;
    localparam int LHP_RX_DC_BIT      = 8;

    // ========================================================
    // Reset values
    localparam logic [1:0]  LHP_CTRL_RESET  = 2'h0;
    localparam logic [7:0]  LHP_BYTE_RESET  = 8'h00;
    localparam logic [2:0]  LHP_EV_RESET    = 3'h0;
    localparam logic [31:0] LHP_WORD_ZERO   = 32'h0000_0000;

    // ========================================================
    // Serial framing and display timing
    localparam logic [2:0] LHP_BIT_LAST     = 3'h7;
    localparam logic [2:0] LHP_BIT_FIRST    = 3'h0;
    localparam int         LHP_SER_DATA_BIT = 7;
    localparam int         LHP_SER_CLK_BIT  = 6;
    localparam logic [7:0] LHP_OSC_HALF     = 8'h0F;
    localparam logic [7:0] LHP_FRAME_LEN    = 8'h40;
    localparam logic [7:0] LHP_CNT_ZERO     = 8'h00;

    // ========================================================
    // Pin synchroniser bit map
    localparam int LHP_SYNC_W   = 21;
    localparam int LHP_S_DCS    = 8;
    localparam int LHP_S_SELN   = 9;
    localparam int LHP_S_SELH   = 10;
    localparam int LHP_S_RD     = 11;
    localparam int LHP_S_WR     = 12;
    localparam int LHP_S_STYLE  = 13;
    localparam int LHP_S_PS     = 14;
    localparam int LHP_S_OSC    = 15;
    localparam int LHP_S_MS     = 16;
    localparam int LHP_S_HRSTN  = 17;
    localparam int LHP_S_PIX    = 18;
    localparam int LHP_S_LC     = 19;
    localparam int LHP_S_BLANK  = 20;

    typedef enum logic [1:0] {
        LHP_MODE_SERIAL,
        LHP_MODE_SEPARATE,
        LHP_MODE_ENABLE
    } lhp_mode_type;

endpackage

/* File: core/lhp_sync.sv */
// Two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
`default_nettype none

module lhp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ========================================================
    // Per-bit chains; stage one feeds stage two only
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta_reg;
            logic stable_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg   <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg   <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule

`default_nettype wire

/* File: core/lhp_port.sv */
// Host bus port of the dot-matrix display controller
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RULE1 - Serial mode: bit 7 data, bit 6 clock
// RULE2 - Host ties unused bits 0-5 in serial
// RULE3 - Data bus released unless chip selected
// RULE4 - Select high means data, low command
// RULE5 - Hardware reset level initialises settings
// RULE6 - Selected only when low-select low, high-select high
// RULE7 - Separate style: read strobe low drives bus
// RULE8 - Enable style: read pin is enable clock
// RULE9 - Separate style: write captured on strobe rise
// RULE10 - Enable style: write pin high read, low write
// RULE11 - Style strap high enable, low separate
// RULE12 - Parallel strap high parallel, low serial write-only
// RULE13 - Oscillator strap runs internal display oscillator
// RULE14 - System supplies display clock when oscillator off
// RULE15 - Master drives timing, slave accepts it
// RULE16 - Alternation pin output in master only
// RULE17 - Blanking pin output in master only
// RULE18 - Static drive only master with indicator on
// RULE19 - Board links timing pins between chips
// RULE20 - Serial: rising edges, MSB first, byte on 8th
// RULE21 - Serial: sample select on every 8th edge
// RULE22 - Deselect resets shift register and counter
// RULE23 - Display reads pipelined, first read dummy
// RULE24 - Enable style: capture on enable falling edge
module lhp_port
    import lhp_pkg::*;
(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host data bus
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    // Host control pins
    input  wire logic        data_command_select,
    input  wire logic        select_low_n,
    input  wire logic        select_high,
    input  wire logic        read_strobe,
    input  wire logic        write_strobe,
    input  wire logic        hw_reset_n,
    // Straps
    input  wire logic        bus_style_select,
    input  wire logic        parallel_select,
    input  wire logic        osc_source_select,
    input  wire logic        master_select,
    // Display timing pins
    input  wire logic        pixel_timing_in,
    output logic             pixel_timing_out,
    output logic             pixel_timing_oe,
    input  wire logic        lc_alternation_in,
    output logic             lc_alternation_out,
    output logic             lc_alternation_oe,
    input  wire logic        display_blank_n_in,
    output logic             display_blank_n_out,
    output logic             display_blank_n_oe,
    output logic             static_drive_out,
    output logic             osc_enable
);

    // ========================================================
    // Pin synchronisation
    logic [LHP_SYNC_W-1:0] pins_async;
    logic [LHP_SYNC_W-1:0] pins_s;
    assign pins_async = {display_blank_n_in, lc_alternation_in,
                         pixel_timing_in, hw_reset_n, master_select,
                         osc_source_select, parallel_select,
                         bus_style_select, write_strobe, read_strobe,
                         select_high, select_low_n, data_command_select,
                         data_in};

    lhp_sync #(.WIDTH(LHP_SYNC_W)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pins_async),
        .sync_out (pins_s)
    );

    logic [7:0]   d_q_reg;
    logic         dc_q_reg;
    logic         rd_q_reg;
    logic         wr_q_reg;
    logic         scl_q_reg;
    logic         pix_q_reg;
    logic         selected;
    logic         settings_rst;
    logic         is_master;
    lhp_mode_type mode;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_q_reg   <= LHP_BYTE_RESET;
            dc_q_reg  <= 1'b0;
            rd_q_reg  <= 1'b0;
            wr_q_reg  <= 1'b0;
            scl_q_reg <= 1'b0;
            pix_q_reg <= 1'b0;
        end else begin
            d_q_reg   <= pins_s[7:0];
            dc_q_reg  <= pins_s[LHP_S_DCS];
            rd_q_reg  <= pins_s[LHP_S_RD];
            wr_q_reg  <= pins_s[LHP_S_WR];
            scl_q_reg <= pins_s[LHP_SER_CLK_BIT];
            pix_q_reg <= pins_s[LHP_S_PIX];
        end
    end

    assign selected     = !pins_s[LHP_S_SELN] && pins_s[LHP_S_SELH]; // RULE6
    assign settings_rst = !pins_s[LHP_S_HRSTN]; // RULE5
    assign is_master    = pins_s[LHP_S_MS];

    // ========================================================
    // Port style from straps
    always_comb begin
        if (!pins_s[LHP_S_PS])
            mode = LHP_MODE_SERIAL; // RULE12
        else if (pins_s[LHP_S_STYLE])
            mode = LHP_MODE_ENABLE; // RULE11
        else
            mode = LHP_MODE_SEPARATE; // RULE11
    end

    // ========================================================
    // Parallel strobes; data taken from the delayed copy for hold margin
    logic rd_act;
    logic rd_act_q_reg;
    logic par_wr_evt;
    logic ser_byte_evt;

    always_comb begin
        rd_act     = 1'b0;
        par_wr_evt = 1'b0;
        case (mode)
            LHP_MODE_SEPARATE: begin
                rd_act     = selected && !pins_s[LHP_S_RD]; // RULE7
                par_wr_evt = selected && pins_s[LHP_S_WR]
                             && !wr_q_reg; // RULE9
            end
            LHP_MODE_ENABLE: begin
                rd_act     = selected && pins_s[LHP_S_RD]
                             && pins_s[LHP_S_WR]; // RULE8 RULE10
                par_wr_evt = selected && !pins_s[LHP_S_RD] && rd_q_reg
                             && !wr_q_reg; // RULE24 RULE10
            end
            default: begin
                rd_act     = 1'b0;
                par_wr_evt = 1'b0;
            end
        endcase
    end

    // ========================================================
    // Serial receiver
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic       scl_rise;
    assign scl_rise = pins_s[LHP_SER_CLK_BIT] && !scl_q_reg;
    assign ser_byte_evt = (mode == LHP_MODE_SERIAL) && selected
                          && scl_rise && (bit_cnt_reg == LHP_BIT_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg   <= LHP_BYTE_RESET;
            bit_cnt_reg <= LHP_BIT_FIRST;
        end else if (!selected || mode != LHP_MODE_SERIAL) begin
            shift_reg   <= LHP_BYTE_RESET; // RULE22
            bit_cnt_reg <= LHP_BIT_FIRST; // RULE22
        end else if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0],
                            d_q_reg[LHP_SER_DATA_BIT]}; // RULE1 RULE20
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // ========================================================
    // Received byte and events; a new event wins over a clear
    logic [7:0] rx_data_reg;
    logic       rx_dc_reg;
    logic [2:0] events_reg;
    logic [2:0] ev_clr;
    logic [2:0] ev_set;
    logic       rx_evt;
    logic       rd_end;
    logic       apb_wr;
    logic       apb_setup;

    assign rx_evt    = par_wr_evt || ser_byte_evt;
    assign rd_end    = rd_act_q_reg && !rd_act;
    assign apb_wr    = psel && penable && pwrite;
    assign apb_setup = psel && !penable;
    assign ev_clr    = (apb_wr && paddr == LHP_OFS_EVENTS) ? pwdata[2:0]
                                                         : LHP_EV_RESET;
    always_comb begin
        ev_set = LHP_EV_RESET;
        ev_set[LHP_EV_RX_VALID]   = rx_evt;
        ev_set[LHP_EV_RX_OVERRUN] = rx_evt && events_reg[LHP_EV_RX_VALID];
        ev_set[LHP_EV_RD_TAKEN]   = rd_end && dc_q_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_reg <= LHP_BYTE_RESET;
            rx_dc_reg   <= 1'b0;
        end else if (settings_rst) begin
            rx_data_reg <= LHP_BYTE_RESET; // RULE5
            rx_dc_reg   <= 1'b0;
        end else if (ser_byte_evt) begin
            rx_data_reg <= {shift_reg[6:0], d_q_reg[LHP_SER_DATA_BIT]}; // RULE20
            rx_dc_reg   <= dc_q_reg; // RULE21 RULE4
        end else if (par_wr_evt) begin
            rx_data_reg <= d_q_reg; // RULE9 RULE24
            rx_dc_reg   <= dc_q_reg; // RULE4
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            events_reg <= LHP_EV_RESET;
        else if (settings_rst)
            events_reg <= LHP_EV_RESET;
        else
            events_reg <= (events_reg & ~ev_clr) | ev_set;
    end

    // ========================================================
    // Read path through the bus holder
    logic [1:0] ctrl_reg;
    logic [7:0] rddata_reg;
    logic [7:0] hstat_reg;
    logic [7:0] holder_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_act_q_reg <= 1'b0;
            holder_reg   <= LHP_BYTE_RESET;
            data_out     <= LHP_BYTE_RESET;
        end else begin
            rd_act_q_reg <= rd_act;
            if (settings_rst)
                holder_reg <= LHP_BYTE_RESET;
            else if (rd_end && dc_q_reg)
                holder_reg <= rddata_reg; // RULE23
            data_out <= pins_s[LHP_S_DCS] ? holder_reg : hstat_reg; // RULE4
        end
    end
    assign data_oe = rd_act && selected; // RULE3 RULE7

    // ========================================================
    // APB registers; zero wait states, read data registered in setup
    logic known;
    assign known = (paddr == LHP_OFS_CTRL)   || (paddr == LHP_OFS_STATUS) ||
                   (paddr == LHP_OFS_RXDATA) || (paddr == LHP_OFS_RDDATA) ||
                   (paddr == LHP_OFS_HSTAT)  || (paddr == LHP_OFS_EVENTS);
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !known;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= LHP_CTRL_RESET;
            rddata_reg <= LHP_BYTE_RESET;
            hstat_reg  <= LHP_BYTE_RESET;
        end else if (settings_rst) begin
            ctrl_reg   <= LHP_CTRL_RESET; // RULE5
            rddata_reg <= LHP_BYTE_RESET;
            hstat_reg  <= LHP_BYTE_RESET;
        end else if (apb_wr) begin
            if (paddr == LHP_OFS_CTRL)
                ctrl_reg <= pwdata[1:0];
            else if (paddr == LHP_OFS_RDDATA)
                rddata_reg <= pwdata[7:0];
            else if (paddr == LHP_OFS_HSTAT)
                hstat_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= LHP_WORD_ZERO;
        else if (apb_setup) begin
            if (paddr == LHP_OFS_CTRL)
                prdata <= {30'h0, ctrl_reg};
            else if (paddr == LHP_OFS_STATUS)
                prdata <= {22'h0, selected, settings_rst, mode,
                           pins_s[LHP_S_BLANK], pins_s[LHP_S_LC],
                           pins_s[LHP_S_MS], pins_s[LHP_S_OSC],
                           pins_s[LHP_S_PS], pins_s[LHP_S_STYLE]};
            else if (paddr == LHP_OFS_RXDATA)
                prdata <= {23'h0, rx_dc_reg, rx_data_reg};
            else if (paddr == LHP_OFS_RDDATA)
                prdata <= {24'h0, rddata_reg};
            else if (paddr == LHP_OFS_HSTAT)
                prdata <= {24'h0, hstat_reg};
            else if (paddr == LHP_OFS_EVENTS)
                prdata <= {29'h0, events_reg};
            else
                prdata <= LHP_WORD_ZERO;
        end
    end

    // ========================================================
    // Display timing: internal oscillator or pixel clock from the pin
    logic [7:0] osc_cnt_reg;
    logic       pix_gen_reg;
    logic [7:0] frame_cnt_reg;
    logic       lc_gen_reg;
    logic       pix_rise;

    assign osc_enable = pins_s[LHP_S_OSC]; // RULE13
    // Without the oscillator the clock must come from the pin
    assign pix_rise = osc_enable ? (osc_cnt_reg == LHP_OSC_HALF && !pix_gen_reg)
                                 : (pins_s[LHP_S_PIX] && !pix_q_reg); // RULE14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_reg <= LHP_CNT_ZERO;
            pix_gen_reg <= 1'b0;
        end else if (!osc_enable) begin
            osc_cnt_reg <= LHP_CNT_ZERO; // RULE13
            pix_gen_reg <= 1'b0;
        end else if (osc_cnt_reg == LHP_OSC_HALF) begin
            osc_cnt_reg <= LHP_CNT_ZERO;
            pix_gen_reg <= !pix_gen_reg; // RULE13
        end else
            osc_cnt_reg <= osc_cnt_reg + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_reg <= LHP_CNT_ZERO;
            lc_gen_reg    <= 1'b0;
        end else if (settings_rst) begin
            frame_cnt_reg <= LHP_CNT_ZERO;
            lc_gen_reg    <= 1'b0;
        end else if (pix_rise) begin
            if (frame_cnt_reg == LHP_FRAME_LEN - 8'h01) begin
                frame_cnt_reg <= LHP_CNT_ZERO;
                lc_gen_reg    <= !lc_gen_reg; // RULE15
            end else
                frame_cnt_reg <= frame_cnt_reg + 8'h01;
        end
    end

    logic lc_level;
    assign lc_level = is_master ? lc_gen_reg : pins_s[LHP_S_LC]; // RULE15

    assign pixel_timing_oe     = is_master && osc_enable; // RULE15 RULE19
    assign pixel_timing_out    = pix_gen_reg;
    assign lc_alternation_oe   = is_master; // RULE16
    assign lc_alternation_out  = lc_gen_reg;
    assign display_blank_n_oe  = is_master; // RULE17
    assign display_blank_n_out = ctrl_reg[LHP_CTRL_DISP_ON];
    assign static_drive_out    = is_master && ctrl_reg[LHP_CTRL_STATIC_ON]
                                 && lc_level; // RULE18

    // ========================================================
    // Checks
    a_bus_release: assert property (@(posedge pclk) disable iff (!presetn)
        !selected |-> !data_oe) // RULE3
        else $error("data bus driven while not selected");
    a_sel_combo: assert property (@(posedge pclk) disable iff (!presetn)
        rx_evt |-> !pins_s[LHP_S_SELN] && pins_s[LHP_S_SELH]) // RULE6
        else $error("byte taken without select");
    a_ser_reset: assert property (@(posedge pclk) disable iff (!presetn)
        !selected |=> bit_cnt_reg == LHP_BIT_FIRST) // RULE22
        else $error("serial counter not reset");
    a_ser_byte: assert property (@(posedge pclk) disable iff (!presetn)
        ser_byte_evt && !settings_rst |=> rx_data_reg == $past(shift_reg << 1
                         | {7'h0, d_q_reg[LHP_SER_DATA_BIT]})) // RULE20
        else $error("serial byte wrong");
    a_ser_dc: assert property (@(posedge pclk) disable iff (!presetn)
        ser_byte_evt && !settings_rst |=> rx_dc_reg == $past(dc_q_reg)) // RULE21
        else $error("select line not sampled");
    a_sep_write: assert property (@(posedge pclk) disable iff (!presetn)
        mode == LHP_MODE_SEPARATE && $rose(pins_s[LHP_S_WR]) && selected
        && !settings_rst |=> rx_data_reg == $past(d_q_reg)) // RULE9
        else $error("strobe rise write missed");
    a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
        par_wr_evt |-> mode == LHP_MODE_ENABLE ? $fell(pins_s[LHP_S_RD])
                       : mode == LHP_MODE_SEPARATE) // RULE24
        else $error("enable write on wrong edge");
    a_serial_ro: assert property (@(posedge pclk) disable iff (!presetn)
        mode == LHP_MODE_SERIAL |-> !data_oe && !par_wr_evt) // RULE12
        else $error("serial mode drove parallel bus");
    a_hw_reset: assert property (@(posedge pclk) disable iff (!presetn)
        settings_rst [*2] |-> ctrl_reg == LHP_CTRL_RESET && !events_reg[0]) // RULE5
        else $error("settings kept in reset");
    a_slave_pins: assert property (@(posedge pclk) disable iff (!presetn)
        !is_master |-> !lc_alternation_oe && !display_blank_n_oe
                       && !static_drive_out && !pixel_timing_oe) // RULE16 RULE17
        else $error("slave drove timing pin");
    a_holder_pipe: assert property (@(posedge pclk) disable iff (!presetn)
        rd_end && dc_q_reg && !settings_rst |=> holder_reg == $past(rddata_reg)) // RULE23
        else $error("holder not refilled");

endmodule

`default_nettype wire

/* File: sim/lhp_host_model.sv */
// Host processor model driving the display port pins
`timescale 1ns/1ns
`default_nettype none
module lhp_host_model (
    // Clock and bus style strap
    input  wire logic       pclk,
    input  wire logic       sty,
    // Host pins
    input  wire logic [7:0] bus,
    output logic      [7:0] bus_val,
    output logic            bus_drive,
    output logic            dcs,
    output logic            seln,
    output logic            selh,
    output logic            rd,
    output logic            wr
);
    // ========================================================
    // Phases last 4 cycles since the port syncs pins over 2-3
    task automatic hold();
        repeat (4) @(posedge pclk);
    endtask
    task automatic idle();
        hold();
        seln      <= 1'b1;
        selh      <= 1'b0;
        bus_drive <= 1'b0;
        rd        <= ~sty;
        wr        <= 1'b1;
        hold();
    endtask
    // ========================================================
    // Write; enable style uses rd as strobe and wr as direction
    task automatic put(input logic s, input logic dc, input logic [7:0] v);
        seln      <= 1'b0;
        selh      <= s;
        dcs       <= dc;
        bus_val   <= v;
        bus_drive <= 1'b1;
        rd        <= 1'b1;
        wr        <= 1'b0;
        hold();
        if (sty) rd <= 1'b0;
        else wr <= 1'b1;
        idle();
    endtask
    // ========================================================
    // Display data read; a released bus shows the inverse pattern
    task automatic get(output logic [7:0] v);
        seln      <= 1'b0;
        selh      <= 1'b1;
        dcs       <= 1'b1;
        bus_val   <= 8'hC3;
        rd        <= sty;
        hold();
        v = bus;
        idle();
    endtask
    // ========================================================
    // Serial frame of n bits; clock pulsed high once per bit, spare lines held low
    task automatic ser(input logic dc, input logic [7:0] v, input int n);
        seln      <= 1'b0;
        selh      <= 1'b1;
        dcs       <= dc;
        bus_drive <= 1'b1;
        bus_val   <= 8'h00;
        hold();
        for (int i = 7; i > 7 - n; i--) begin
            bus_val <= {v[i], 7'h00};
            hold();
            bus_val <= {v[i], 1'b1, 6'h00};
            hold();
        end
        bus_val <= 8'h00;
        hold();
        seln    <= 1'b1;
        selh    <= 1'b0;
        hold();
    endtask
    initial begin
        bus_val   = 8'h00;
        bus_drive = 1'b0;
        dcs       = 1'b0;
        seln      = 1'b1;
        selh      = 1'b0;
        rd        = 1'b1;
        wr        = 1'b1;
    end
endmodule
`default_nettype wire

/* File: sim/lhp_port_test.sv */
// Self-checking bench for the display host bus port
`timescale 1ns/1ns
`default_nettype none
module lhp_port_test;
    import lhp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, slv, pready;
    logic        hdrv, dcs, seln, selh, rd, wr, hrst_n, sty, ps, osc, ms;
    logic        pslverr, data_oe, lc_oe, lc_out, bl_oe, bl_out, st, osc_en;
    logic        pix_in, pix_oe;
    logic [7:0]  paddr, hv, data_out, b;
    logic [31:0] pwdata, prdata, junk;
    wire  [7:0]  bus = data_oe ? data_out : (hdrv ? hv : ~hv);
    int          fails = 0;
    int          samples_checked = 0;
    always #50 pclk = ~pclk;
    always @(posedge pclk) pix_in <= ~pix_in;
    lhp_port lhp_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(bus),
        .data_out(data_out), .data_oe(data_oe), .data_command_select(dcs),
        .select_low_n(seln), .select_high(selh), .read_strobe(rd),
        .write_strobe(wr), .hw_reset_n(hrst_n), .bus_style_select(sty),
        .parallel_select(ps), .osc_source_select(osc), .master_select(ms),
        .pixel_timing_in(pix_in), .pixel_timing_out(),
        .pixel_timing_oe(pix_oe),
        .lc_alternation_in(1'b0), .lc_alternation_out(lc_out),
        .lc_alternation_oe(lc_oe), .display_blank_n_in(1'b0),
        .display_blank_n_out(bl_out), .display_blank_n_oe(bl_oe),
        .static_drive_out(st), .osc_enable(osc_en));
    lhp_host_model lhp_host_model_inst (.pclk(pclk), .sty(sty), .bus(bus),
        .bus_val(hv), .bus_drive(hdrv), .dcs(dcs), .seln(seln),
        .selh(selh), .rd(rd), .wr(wr));
    // ========================================================
    // Reporting
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, e, input string m);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // ========================================================
    // APB master; one idle cycle keeps transfers apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        slv = pslverr;
        if (n >= 16) fails++;
        if (n >= 16) conclude();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string m);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        cmp(r, e, m);
    endtask
    // ========================================================
    // Main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, sty, osc, ms, pix_in} = 9'h000;
        {hrst_n, ps, paddr, pwdata} = {2'h3, 8'h00, 32'h0000_0000};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(LHP_OFS_CTRL, 32'h0, "ctrl reset");
        rchk(8'h18, 32'h0, "unmapped");
        cmp(slv, 1'b1, "slverr");
        cmp(data_oe, 1'b0, "idle bus");
        lhp_host_model_inst.put(1'b1, 1'b1, 8'hA5);
        rchk(LHP_OFS_RXDATA, 32'h1A5, "separate write");
        rchk(LHP_OFS_EVENTS, 32'h1, "rx event");
        apb(1'b1, LHP_OFS_EVENTS, 32'h7, junk);
        lhp_host_model_inst.put(1'b0, 1'b1, 8'h11);
        rchk(LHP_OFS_EVENTS, 32'h0, "deselected");
        apb(1'b1, LHP_OFS_RDDATA, 32'h5A, junk);
        lhp_host_model_inst.get(b);
        cmp(b, 8'h00, "dummy read");
        lhp_host_model_inst.get(b);
        cmp(b, 8'h5A, "held read");
        rchk(LHP_OFS_EVENTS, 32'h4, "read event");
        sty <= 1'b1;
        lhp_host_model_inst.idle();
        lhp_host_model_inst.put(1'b1, 1'b0, 8'h3C);
        rchk(LHP_OFS_RXDATA, 32'h03C, "enable write");
        lhp_host_model_inst.get(b);
        cmp(b, 8'h5A, "enable read");
        apb(1'b1, LHP_OFS_CTRL, 32'h3, junk);
        ms  <= 1'b1;
        osc <= 1'b1;
        lhp_host_model_inst.idle();
        cmp({lc_oe, bl_oe, bl_out, osc_en, pix_oe}, 5'h1F, "master");
        repeat (2200) if (!lc_out) @(posedge pclk);
        cmp({st, lc_out}, 2'h3, "static drive");
        ms  <= 1'b0;
        osc <= 1'b0;
        lhp_host_model_inst.idle();
        cmp({lc_oe, bl_oe, st, osc_en, pix_oe}, 5'h00, "slave");
        b[0] = lc_out;
        repeat (300) if (lc_out == b[0]) @(posedge pclk);
        cmp(lc_out, !b[0], "pin clock");
        hrst_n <= 1'b0;
        lhp_host_model_inst.idle();
        hrst_n <= 1'b1;
        lhp_host_model_inst.idle();
        rchk(LHP_OFS_CTRL, 32'h0, "hw reset");
        ps <= 1'b0;
        lhp_host_model_inst.idle();
        lhp_host_model_inst.ser(1'b0, 8'hFF, 3);
        lhp_host_model_inst.ser(1'b1, 8'h96, 8);
        rchk(LHP_OFS_RXDATA, 32'h196, "serial byte");
        conclude();
    end
endmodule
`default_nettype wire
